// >>> hdl/rspt_params.svh
`ifndef RSPT_PARAMS_SVH
`define RSPT_PARAMS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define RSPT_ADDR_STATUS 12'h000
`define RSPT_ADDR_MASK 12'h004
`define RSPT_ADDR_CONFIG 12'h008
`define RSPT_ADDR_CONTROL 12'h00C
// ----------------------------------------
// Status and mask bit positions
// ----------------------------------------
`define RSPT_BIT_RI_N 0
`define RSPT_BIT_OVF 1
`define RSPT_BIT_UNF 2
`define RSPT_BIT_POR 3
`define RSPT_BIT_PGM 4
`define RSPT_EV_W 5
// Reset-instruction flag reads 1 until a reset instruction clears it
`define RSPT_STATUS_RST 5'h01
// ----------------------------------------
// Config bit positions
// ----------------------------------------
`define RSPT_CFG_STK_EN 0
`define RSPT_CFG_POWERUP_TIMER_N 1
`define RSPT_CFG_EXTERNAL_MASTER_RESET_EN 2
`define RSPT_CFG_OST_REQ 3
`define RSPT_CFG_RST 4'h1
// ----------------------------------------
// Timing
// ----------------------------------------
`define RSPT_CLK_HZ 40000000
`define RSPT_POWERUP_TIMER_MS 64
`define RSPT_POWERUP_TIMER_CYC ((`RSPT_CLK_HZ / 1000) * `RSPT_POWERUP_TIMER_MS)
`define RSPT_EXTERNAL_MASTER_RESET_CYC 10
`define RSPT_OST_CYC 1024
`endif

// >>> hdl/rspt_pkg.sv
package rspt_pkg;
  typedef enum logic [2:0] {
    RSPT_HOLD,
    RSPT_WAIT_TIMERS,
    RSPT_WAIT_PIN,
    RSPT_PIN_DELAY,
    RSPT_RUN
  } rspt_state_t;

  typedef struct packed {
    logic reset_instr;
    logic stack_over;
    logic stack_under;
    logic prog_exit;
    logic selfprog;
  } rspt_events_t;
endpackage : rspt_pkg

// >>> hdl/rspt_sequencer.sv
// Implementation choices: the address map and register access over APB.
`include "rspt_params.svh"
module rspt_sequencer #(
  parameter int POWERUP_TIMER_CYC = `RSPT_POWERUP_TIMER_CYC,
  parameter int OST_CYC = `RSPT_OST_CYC,
  parameter int EXTERNAL_MASTER_RESET_CYC = `RSPT_EXTERNAL_MASTER_RESET_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic por_bor_active,
  input wire logic external_master_reset_n,
  input wire rspt_pkg::rspt_events_t events,
  output logic core_reset,
  output logic irq,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  rspt_pkg::rspt_state_t state;
  rspt_pkg::rspt_state_t next_state;
  logic [`RSPT_EV_W-1:0] status;
  logic [`RSPT_EV_W-1:0] mask;
  logic [3:0] config_bits;
  logic [31:0] powerup_timer_cnt;
  logic [31:0] ost_cnt;
  logic [7:0] pin_cnt;
  logic por_seen;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire bus_wr = psel && penable && pwrite;
  wire bus_rd = psel && penable && !pwrite;
  wire sel_status = paddr == `RSPT_ADDR_STATUS;
  wire sel_mask = paddr == `RSPT_ADDR_MASK;
  wire sel_config = paddr == `RSPT_ADDR_CONFIG;
  wire sel_control = paddr == `RSPT_ADDR_CONTROL;
  wire sel_any = sel_status || sel_mask || sel_config || sel_control;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !sel_any;

  // ----------------------------------------
  // Reset sources
  // ----------------------------------------
  wire stack_en = config_bits[`RSPT_CFG_STK_EN];
  wire powerup_timer_on = !config_bits[`RSPT_CFG_POWERUP_TIMER_N];
  wire external_master_reset_en = config_bits[`RSPT_CFG_EXTERNAL_MASTER_RESET_EN];
  wire ost_req = config_bits[`RSPT_CFG_OST_REQ];
  wire stack_hit = stack_en && (events.stack_over || events.stack_under);
  // Software reset via control word bit 0 acts as the reset instruction too
  wire sw_rst = events.reset_instr || (bus_wr && sel_control && pwdata[0]);
  // Programming exit replays the power-on path; self-programming is ignored
  wire por_like = por_bor_active || events.prog_exit;
  wire warm_rst = sw_rst || stack_hit;
  wire pin_low = external_master_reset_en && !external_master_reset_n;
  wire powerup_timer_done = !powerup_timer_on || (powerup_timer_cnt >= 32'(POWERUP_TIMER_CYC));
  wire ost_done = !ost_req || (ost_cnt >= 32'(OST_CYC));
  wire timers_done = powerup_timer_done && ost_done;

  // ----------------------------------------
  // Start-up sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      rspt_pkg::RSPT_HOLD: begin
        if (!por_like) begin
          next_state = rspt_pkg::RSPT_WAIT_TIMERS;
        end
      end
      rspt_pkg::RSPT_WAIT_TIMERS: begin
        if (timers_done) begin
          next_state = pin_low ? rspt_pkg::RSPT_WAIT_PIN : rspt_pkg::RSPT_RUN;
        end
      end
      rspt_pkg::RSPT_WAIT_PIN: begin
        if (!pin_low) begin
          next_state = rspt_pkg::RSPT_PIN_DELAY;
        end
      end
      rspt_pkg::RSPT_PIN_DELAY: begin
        if (pin_low) begin
          next_state = rspt_pkg::RSPT_WAIT_PIN;
        end else if (pin_cnt >= 8'(EXTERNAL_MASTER_RESET_CYC - 1)) begin
          next_state = rspt_pkg::RSPT_RUN;
        end
      end
      rspt_pkg::RSPT_RUN: begin
        if (pin_low) begin
          next_state = rspt_pkg::RSPT_WAIT_PIN;
        end
      end
      default: next_state = rspt_pkg::RSPT_HOLD;
    endcase
    if (por_like) begin
      next_state = rspt_pkg::RSPT_HOLD;
    end else if (warm_rst) begin
      // Warm resets skip the power-up timer, which only follows POR/BOR or programming exit
      next_state = rspt_pkg::RSPT_PIN_DELAY;
    end
  end

  // Core held in reset in every state but run
  assign core_reset = state != rspt_pkg::RSPT_RUN;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= rspt_pkg::RSPT_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Timers count on the free-running clock; a fresh POR restarts them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powerup_timer_cnt <= 32'h00000000;
    end else if (state != rspt_pkg::RSPT_WAIT_TIMERS) begin
      powerup_timer_cnt <= 32'h00000000;
    end else if (!powerup_timer_done) begin
      powerup_timer_cnt <= powerup_timer_cnt + 32'h00000001;
    end
  end

  // Holding at the terminal count keeps the done flag from wrapping away
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ost_cnt <= 32'h00000000;
    end else if (state != rspt_pkg::RSPT_WAIT_TIMERS) begin
      ost_cnt <= 32'h00000000;
    end else if (!ost_done) begin
      ost_cnt <= ost_cnt + 32'h00000001;
    end
  end

  // A warm reset inside the pin delay restarts the full delay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_cnt <= 8'h00;
    end else if (state != rspt_pkg::RSPT_PIN_DELAY || warm_rst) begin
      pin_cnt <= 8'h00;
    end else begin
      pin_cnt <= pin_cnt + 8'h01;
    end
  end

  // ----------------------------------------
  // Status, mask, config
  // ----------------------------------------
  logic [`RSPT_EV_W-1:0] ev_set;
  logic [`RSPT_EV_W-1:0] ev_clr;
  always_comb begin
    ev_set = '0;
    ev_set[`RSPT_BIT_OVF] = stack_en && events.stack_over;
    ev_set[`RSPT_BIT_UNF] = stack_en && events.stack_under;
    ev_set[`RSPT_BIT_POR] = por_bor_active;
    ev_set[`RSPT_BIT_PGM] = events.prog_exit;
    ev_clr = (bus_wr && sel_status) ? pwdata[`RSPT_EV_W-1:0] : '0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= `RSPT_STATUS_RST;
    end else begin
      // Set wins over a same-cycle write-one-to-clear
      status <= (status & ~ev_clr) | ev_set;
      // Active-low flag: a reset instruction drives it to zero, software writes 1 to rearm
      if (sw_rst) begin
        status[`RSPT_BIT_RI_N] <= 1'b0;
      end else if (bus_wr && sel_status && pwdata[`RSPT_BIT_RI_N]) begin
        status[`RSPT_BIT_RI_N] <= 1'b1;
      end else begin
        status[`RSPT_BIT_RI_N] <= status[`RSPT_BIT_RI_N];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask <= '0;
      config_bits <= `RSPT_CFG_RST;
    end else begin
      if (bus_wr && sel_mask) begin
        mask <= pwdata[`RSPT_EV_W-1:0];
      end
      if (bus_wr && sel_config) begin
        config_bits <= pwdata[3:0];
      end
    end
  end

  // Reset-instruction flag is active low, so its event is the zero level
  wire [`RSPT_EV_W-1:0] pending = {status[`RSPT_EV_W-1:1], ~status[`RSPT_BIT_RI_N]};
  assign irq = |(pending & mask);

  wire [31:0] rd_mux = sel_status ? {27'h0000000, status} :
                       sel_mask ? {27'h0000000, mask} :
                       sel_config ? {28'h0000000, config_bits} :
                       sel_control ? {29'h00000000, state} : 32'h00000000;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // Assertion helpers
  // ----------------------------------------
  // Cycles spent in the pin delay since entry or since a warm reset restarted it
  logic [7:0] chk_pin_len;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chk_pin_len <= 8'h00;
    end else if (state != rspt_pkg::RSPT_PIN_DELAY || warm_rst) begin
      chk_pin_len <= 8'h00;
    end else if (chk_pin_len != 8'hFF) begin
      chk_pin_len <= chk_pin_len + 8'h01;
    end
  end

  // Cycles spent waiting for the timers; wide enough for the full power-up delay
  logic [31:0] chk_wait_len;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chk_wait_len <= 32'h00000000;
    end else if (state != rspt_pkg::RSPT_WAIT_TIMERS) begin
      chk_wait_len <= 32'h00000000;
    end else begin
      chk_wait_len <= chk_wait_len + 32'h00000001;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_powerup_timer_holds: assert property (@(posedge clk) disable iff (rst)
    state == rspt_pkg::RSPT_WAIT_TIMERS |-> core_reset) else $error("core ran in timers");
  a_por_holds: assert property (@(posedge clk) disable iff (rst)
    por_bor_active |=> state == rspt_pkg::RSPT_HOLD) else $error("por not held");
  a_ri_clear: assert property (@(posedge clk) disable iff (rst)
    events.reset_instr |=> !status[`RSPT_BIT_RI_N] && core_reset) else $error("ri not zero");
  a_stack_off: assert property (@(posedge clk) disable iff (rst)
    !stack_en && !por_like && !events.reset_instr && !pin_low && state == rspt_pkg::RSPT_RUN
    && !(bus_wr && sel_control) |=> !core_reset) else $error("stack reset disabled");
  a_ovf_flag: assert property (@(posedge clk) disable iff (rst)
    stack_en && events.stack_over |=> status[`RSPT_BIT_OVF]) else $error("ovf flag");
  a_pgm_like_por: assert property (@(posedge clk) disable iff (rst)
    events.prog_exit |=> state == rspt_pkg::RSPT_HOLD) else $error("prog exit");
  a_pin_delay: assert property (@(posedge clk) disable iff (rst)
    state == rspt_pkg::RSPT_PIN_DELAY && chk_pin_len == 8'(EXTERNAL_MASTER_RESET_CYC - 1) && !por_like
    && !warm_rst && !pin_low |=> state == rspt_pkg::RSPT_RUN) else $error("pin delay");

  a_pin_early: assert property (@(posedge clk) disable iff (rst)
    state == rspt_pkg::RSPT_PIN_DELAY && chk_pin_len < 8'(EXTERNAL_MASTER_RESET_CYC - 1) |=> core_reset)
    else $error("pin delay short");

  a_powerup_timer_length: assert property (@(posedge clk) disable iff (rst)
    $fell(core_reset) && $past(state) == rspt_pkg::RSPT_WAIT_TIMERS && $past(powerup_timer_on)
    |-> $past(chk_wait_len) >= 32'(POWERUP_TIMER_CYC)) else $error("power-up delay short");

  a_ost_length: assert property (@(posedge clk) disable iff (rst)
    $fell(core_reset) && $past(state) == rspt_pkg::RSPT_WAIT_TIMERS && $past(ost_req)
    |-> $past(chk_wait_len) >= 32'(OST_CYC)) else $error("oscillator delay short");

  a_por_no_run: assert property (@(posedge clk) disable iff (rst)
    por_like |=> core_reset) else $error("core ran during por");

  a_hold_timers: assert property (@(posedge clk) disable iff (rst)
    state == rspt_pkg::RSPT_HOLD |=> powerup_timer_cnt == 32'h00000000)
    else $error("timer ran before release");

  a_pin_blocks: assert property (@(posedge clk) disable iff (rst)
    pin_low |=> core_reset) else $error("core ran with pin low");

  a_unf_flag: assert property (@(posedge clk) disable iff (rst)
    stack_en && events.stack_under |=> status[`RSPT_BIT_UNF]) else $error("unf flag");

  a_stack_reset: assert property (@(posedge clk) disable iff (rst)
    stack_hit && !por_like |=> state == rspt_pkg::RSPT_PIN_DELAY)
    else $error("stack event did not reset");

  a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    status[`RSPT_BIT_OVF] && !(bus_wr && sel_status && pwdata[`RSPT_BIT_OVF])
    |=> status[`RSPT_BIT_OVF]) else $error("ovf flag lost");

  a_ri_rearm: assert property (@(posedge clk) disable iff (rst)
    bus_wr && sel_status && pwdata[`RSPT_BIT_RI_N] && !sw_rst |=> status[`RSPT_BIT_RI_N])
    else $error("ri flag not rearmed");

  a_sw_write: assert property (@(posedge clk) disable iff (rst)
    bus_wr && sel_control && pwdata[0] && !por_like |=> state == rspt_pkg::RSPT_PIN_DELAY)
    else $error("software reset ignored");

  a_irq_quiet: assert property (@(posedge clk) disable iff (rst)
    mask == '0 |-> !irq) else $error("irq with all masked");

  a_mask_write: assert property (@(posedge clk) disable iff (rst)
    bus_wr && sel_mask |=> mask == $past(pwdata[`RSPT_EV_W-1:0])) else $error("mask write");

  a_config_write: assert property (@(posedge clk) disable iff (rst)
    bus_wr && sel_config |=> config_bits == $past(pwdata[3:0])) else $error("config write");

  a_bypass: assert property (@(posedge clk) disable iff (rst)
    state == rspt_pkg::RSPT_WAIT_TIMERS && !powerup_timer_on && !ost_req && !pin_low && !por_like
    && !warm_rst |=> state == rspt_pkg::RSPT_RUN) else $error("bypass");
  a_selfprog: assert property (@(posedge clk) disable iff (rst)
    state == rspt_pkg::RSPT_RUN && events.selfprog && !por_like && !warm_rst && !pin_low
    |=> !core_reset) else $error("selfprog reset");
  c_run: cover property (@(posedge clk) disable iff (rst) $fell(core_reset));
  c_ovf: cover property (@(posedge clk) disable iff (rst) stack_hit);
  c_pin: cover property (@(posedge clk) disable iff (rst) state == rspt_pkg::RSPT_WAIT_PIN);
  c_pin_run: cover property (@(posedge clk) disable iff (rst)
    state == rspt_pkg::RSPT_PIN_DELAY ##1 state == rspt_pkg::RSPT_RUN);
  c_prog: cover property (@(posedge clk) disable iff (rst) events.prog_exit);
endmodule : rspt_sequencer

// >>> sim/tb_rspt_sequencer.sv
`include "rspt_params.svh"
module tb_rspt_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Setup
  // ----------------------------------------
  // Short counts keep the run brief; the power-up timer, oscillator and pin delay expectations derive from these
  localparam int POWERUP_TIMER = 50;
  localparam int OST = 8;
  localparam int PIN = 10;
  logic clk, rst, por, pin_n, psel, penable, pwrite, pready, pslverr, core_reset, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  rspt_pkg::rspt_events_t ev;
  int fails, total_checks, cyc, n;
  rspt_sequencer #(.POWERUP_TIMER_CYC(POWERUP_TIMER), .OST_CYC(OST), .EXTERNAL_MASTER_RESET_CYC(PIN)) u_dut (
    .clk(clk), .rst(rst), .por_bor_active(por), .external_master_reset_n(pin_n),
    .events(ev), .core_reset(core_reset), .irq(irq), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr)
  );
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard: far above the several hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      summarize();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic rng(input string name, input int v, input int lo, input int hi);
    chk(name, 32'(v >= lo && v <= hi), 32'h1);
  endtask : rng
  // Request held until pready is sampled high; read data taken at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdm(input string name, input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd & m, exp);
  endtask : rdm
  task automatic count(input int cap);
    n = 0;
    // Sample just after the edge so the state update has settled
    #1;
    while (core_reset === 1'b1 && n < cap) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : count
  task automatic boot(input logic [31:0] cfg, input int hold, input int cap);
    apb(1'b1, `RSPT_ADDR_CONFIG, cfg);
    por <= 1'b1;
    repeat (hold) @(posedge clk);
    por <= 1'b0;
    @(posedge clk);
    count(cap);
  endtask : boot
  task automatic pulse(input logic [4:0] v);
    @(posedge clk);
    ev <= rspt_pkg::rspt_events_t'(v);
    @(posedge clk);
    ev <= '0;
    @(posedge clk);
  endtask : pulse
  task automatic quiet(input string name);
    n = 0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (core_reset !== 1'b0) n++;
    end
    rng(name, n, 0, 0);
  endtask : quiet
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1; por = 1'b0; pin_n = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; ev = '0; fails = 0; total_checks = 0; cyc = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("core_reset_after_rst", 32'(core_reset), 32'h1);
    rdm("config_reset", `RSPT_ADDR_CONFIG, 32'hFFFFFFFF, 32'h1);
    rdm("mask_reset", `RSPT_ADDR_MASK, 32'hFFFFFFFF, 32'h0);
    count(POWERUP_TIMER + 20);
    boot(32'h0, 100, 1000);
    rng("powerup_timer_delay", n, POWERUP_TIMER - 2, POWERUP_TIMER + 4);
    boot(32'h2, 100, 1000);
    rng("powerup_timer_bypass", n, 0, 3);
    boot(32'hA, 5, 1000);
    rng("osc_timer", n, OST - 2, OST + 4);
    pin_n <= 1'b0;
    boot(32'h4, 5, POWERUP_TIMER + 30);
    rng("pin_held", n, POWERUP_TIMER + 30, POWERUP_TIMER + 30);
    pin_n <= 1'b1;
    count(100);
    rng("pin_delay", n, PIN - 1, PIN + 2);
    boot(32'h3, 5, 100);
    pulse(5'h10);
    count(100);
    rng("reset_instr", n, PIN - 1, PIN + 2);
    rdm("ri_flag", `RSPT_ADDR_STATUS, 32'h1, 32'h0);
    for (int i = 0; i < 2; i++) begin
      pulse(5'h08 >> i);
      count(100);
      rng("stack_reset", n, PIN - 1, PIN + 2);
      rdm("stack_flag", `RSPT_ADDR_STATUS, 32'h6, 32'h2 << i);
      apb(1'b1, `RSPT_ADDR_MASK, 32'h6);
      #1 chk("irq_on", 32'(irq), 32'h1);
      apb(1'b1, `RSPT_ADDR_MASK, 32'h0);
      #1 chk("irq_masked", 32'(irq), 32'h0);
      apb(1'b1, `RSPT_ADDR_MASK, 32'h6);
      apb(1'b1, `RSPT_ADDR_STATUS, 32'h6);
      #1 chk("irq_cleared", 32'(irq), 32'h0);
      rdm("stack_w1c", `RSPT_ADDR_STATUS, 32'h6, 32'h0);
    end
    apb(1'b1, `RSPT_ADDR_CONFIG, 32'h2);
    pulse(5'h08);
    quiet("stack_disabled");
    pulse(5'h01);
    quiet("selfprog");
    apb(1'b1, `RSPT_ADDR_CONFIG, 32'h0);
    pulse(5'h02);
    count(POWERUP_TIMER + 40);
    rng("prog_exit", n, POWERUP_TIMER - 2, POWERUP_TIMER + 14);
    rdm("prog_flag", `RSPT_ADDR_STATUS, 32'h10, 32'h10);
    apb(1'b1, `RSPT_ADDR_CONTROL, 32'h1);
    @(posedge clk);
    count(100);
    rng("sw_reset", n, PIN - 2, PIN + 2);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped_data", rd, 32'h0);
    chk("unmapped_err", 32'(err), 32'h1);
    summarize();
  end
endmodule : tb_rspt_sequencer
